// ===== design/pllcfg_pkg.sv
package pllcfg_pkg;
    // Bus address of this slave, sent most significant bit first
    localparam logic [6:0] SLAVE_ADDR = 7'h65;
    // Byte positions within a write transfer (0 is the address byte)
    localparam logic [2:0] POS_DUMMY_LAST = 3'h2;
    localparam logic [2:0] POS_REF_CFG = 3'h3;
    localparam logic [2:0] POS_FB_CFG = 3'h4;
    localparam logic [2:0] POS_SPARE_CFG = 3'h5;
    // Field positions in the reference divider byte
    localparam int REF_BYPASS_BIT = 7;
    localparam int RATIO_EN_BIT = 6;
    localparam int REF_FIELD_MSB = 5;
    // Reset values of the configuration latches
    localparam logic [7:0] REF_CFG_RST = 8'h00;
    localparam logic [7:0] FB_CFG_RST = 8'h00;
    localparam logic [7:0] SPARE_CFG_RST = 8'h00;
    // Divider arithmetic
    localparam logic [9:0] FB_OFFSET = 10'h003;
    localparam logic [6:0] REF_OFFSET = 7'h02;
    localparam logic [6:0] REF_BYPASS_DIV = 7'h01;
    localparam logic [9:0] MULT_PIN_LOW = 10'h010;
    localparam logic [9:0] MULT_PIN_HIGH = 10'h008;
    localparam logic [6:0] MULT_REF_DIV = 7'h01;
    // Bits in a byte
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;

    // Serial engine states, Gray coded along the usual path
    typedef enum logic [2:0] {
        PLLCFG_IDLE = 3'b000,
        PLLCFG_RX = 3'b001,
        PLLCFG_ACK = 3'b011,
        PLLCFG_TX = 3'b010,
        PLLCFG_TXACK = 3'b110,
        PLLCFG_IGNORE = 3'b111
    } pllcfg_state_t;
endpackage

// ===== design/pllcfg_sync.sv
// Two-stage synchroniser for one pin
module pllcfg_sync import pllcfg_pkg::*; (
    input wire logic clk,
    input wire logic rst,
    input wire logic pin,
    output logic synced
);
    typedef struct packed {
        logic meta;
        logic stable;
    } pllcfg_sync_t;

    pllcfg_sync_t st_ff;
    pllcfg_sync_t nxt_st;

    // First stage is read only by the second stage
    always_comb begin
        nxt_st.meta = pin;
        nxt_st.stable = st_ff.meta;
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign synced = st_ff.stable;
endmodule // pllcfg_sync

// ===== design/pllcfg_top.sv
// Overview of operation
// - Data changes only while clock is low, stable during high phase.
// - Acknowledger pulls data low before rising edge, holds past falling edge.
// - Each segment carries eight data bits then an acknowledge slot.
// - First byte after start is address plus direction, acknowledged by slave.
// - Direction 0 means master writes, direction 1 means master reads.
// - Receiver of each data byte drives an acknowledge.
// - Two dummy bytes follow the address and are not stored.
// - Only three configuration bytes latched, third reserved, extras ignored.
// - Slave answers only to address 1100101, sent MSB first.
// - Byte one: bypass, ratio enable, six-bit ref field; byte two feedback.
// - Ratio enable resets low; when high, programmed dividers set ratio.
// - Feedback division is (field+3)*2; reference division is field+2.
// - Bypass resets low; when high reference division is one.
// - With ratio enable low the multiplier comes from the select pin.
// - Select pin low gives sixteen, high or open gives eight.
// - Output frequency is reference times feedback over reference division.
// - Feedback counter is eight bits, reference counter six bits.
// - Output gate pin low disables the differential output, high enables it.
// - Bus lines are pulled up; parties only pull low or release.
module pllcfg_top import pllcfg_pkg::*; (
    input wire logic clk,
    input wire logic rst,
    input wire logic two_wire_clock_pin,
    input wire logic two_wire_line_in,
    output logic two_wire_line_out,
    output logic two_wire_line_oe,
    input wire logic mult_select_pin,
    input wire logic output_gate_pin,
    output logic [7:0] ref_divider_config,
    output logic [7:0] feedback_divider_config,
    output logic [7:0] spare_config_byte,
    output logic [9:0] loop_fb_division,
    output logic [6:0] loop_ref_division,
    output logic clock_output_enable
);
    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers
    logic scl_s;
    logic sda_s;
    logic sel_s;
    logic gate_s;

    pllcfg_sync u_sync_scl (
        .clk(clk),
        .rst(rst),
        .pin(two_wire_clock_pin),
        .synced(scl_s)
    );
    pllcfg_sync u_sync_sda (
        .clk(clk),
        .rst(rst),
        .pin(two_wire_line_in),
        .synced(sda_s)
    );
    pllcfg_sync u_sync_sel (
        .clk(clk),
        .rst(rst),
        .pin(mult_select_pin),
        .synced(sel_s)
    );
    pllcfg_sync u_sync_gate (
        .clk(clk),
        .rst(rst),
        .pin(output_gate_pin),
        .synced(gate_s)
    );

    ////////////////////////////////////////////////////////////////////////////
    // State of the block
    typedef struct packed {
        logic scl_d;
        logic sda_d;
        pllcfg_state_t state;
        logic [3:0] bit_cnt;
        logic [7:0] shift;
        logic [2:0] byte_pos;
        logic read_dir;
        logic ack_seen_fall;
        logic line_oe;
        logic [7:0] ref_cfg;
        logic [7:0] fb_cfg;
        logic [7:0] spare_cfg;
        logic [9:0] fb_div;
        logic [6:0] ref_div;
        logic out_en;
    } pllcfg_top_t;

    pllcfg_top_t st_ff;
    pllcfg_top_t nxt_st;

    logic scl_rise;
    logic scl_fall;
    logic start_cond;
    logic stop_cond;

    // Edges and bus conditions, seen only from the settled copies
    always_comb begin
        scl_rise = scl_s && !st_ff.scl_d;
        scl_fall = !scl_s && st_ff.scl_d;
        start_cond = scl_s && st_ff.scl_d && st_ff.sda_d && !sda_s;
        stop_cond = scl_s && st_ff.scl_d && !st_ff.sda_d && sda_s;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Serial engine and divider logic
    always_comb begin
        nxt_st = st_ff;
        nxt_st.scl_d = scl_s;
        nxt_st.sda_d = sda_s;
        if (start_cond) begin
            // A repeated start restarts address reception
            nxt_st.state = PLLCFG_RX;
            nxt_st.bit_cnt = 4'h0;
            nxt_st.byte_pos = 3'h0;
            nxt_st.line_oe = 1'b0;
        end else if (stop_cond) begin
            nxt_st.state = PLLCFG_IDLE;
            nxt_st.line_oe = 1'b0;
        end else begin
            unique case (st_ff.state)
                PLLCFG_IDLE, PLLCFG_IGNORE: begin
                    nxt_st.line_oe = 1'b0;
                end
                PLLCFG_RX: begin
                    // Sample on rising edge, data is stable while clock high
                    if (scl_rise) begin
                        nxt_st.shift = {st_ff.shift[6:0], sda_s};
                        nxt_st.bit_cnt = st_ff.bit_cnt + 4'h1;
                    end
                    if (scl_fall && st_ff.bit_cnt == BITS_PER_BYTE) begin
                        nxt_st.bit_cnt = 4'h0;
                        if (st_ff.byte_pos == 3'h0) begin
                            if (st_ff.shift[7:1] == SLAVE_ADDR) begin
                                nxt_st.read_dir = st_ff.shift[0];
                                nxt_st.state = PLLCFG_ACK;
                                nxt_st.line_oe = 1'b1;
                            end else begin
                                nxt_st.state = PLLCFG_IGNORE;
                            end
                        end else begin
                            // Dummy bytes are acknowledged but not kept
                            unique case (st_ff.byte_pos)
                                POS_REF_CFG: nxt_st.ref_cfg = st_ff.shift;
                                POS_FB_CFG: nxt_st.fb_cfg = st_ff.shift;
                                POS_SPARE_CFG: nxt_st.spare_cfg = st_ff.shift;
                                default: ;
                            endcase
                            nxt_st.state = PLLCFG_ACK;
                            nxt_st.line_oe = 1'b1;
                        end
                        if (st_ff.byte_pos != POS_SPARE_CFG + 3'h1) begin
                            nxt_st.byte_pos = st_ff.byte_pos + 3'h1;
                        end
                    end
                end
                PLLCFG_ACK: begin
                    // Hold low through the high phase; on the falling edge release on writes, drive the first data bit on reads
                    if (scl_fall) begin
                        nxt_st.line_oe = 1'b0;
                        if (st_ff.read_dir) begin
                            nxt_st.state = PLLCFG_TX;
                            nxt_st.shift = {st_ff.ref_cfg[6:0], 1'b0};
                            nxt_st.bit_cnt = 4'h1;
                            nxt_st.line_oe = !st_ff.ref_cfg[7];
                        end else begin
                            nxt_st.state = PLLCFG_RX;
                        end
                    end
                end
                PLLCFG_TX: begin
                    // Read returns the first configuration byte repeatedly
                    if (scl_fall) begin
                        if (st_ff.bit_cnt == BITS_PER_BYTE) begin
                            nxt_st.line_oe = 1'b0;
                            nxt_st.state = PLLCFG_TXACK;
                        end else begin
                            nxt_st.line_oe = !st_ff.shift[7];
                            nxt_st.shift = {st_ff.shift[6:0], 1'b0};
                            nxt_st.bit_cnt = st_ff.bit_cnt + 4'h1;
                        end
                    end
                end
                PLLCFG_TXACK: begin
                    // Master nack ends reading; ack sends the byte again
                    if (scl_rise) begin
                        nxt_st.ack_seen_fall = !sda_s;
                    end
                    if (scl_fall) begin
                        if (st_ff.ack_seen_fall) begin
                            nxt_st.state = PLLCFG_TX;
                            nxt_st.shift = {st_ff.ref_cfg[6:0], 1'b0};
                            nxt_st.bit_cnt = 4'h1;
                            nxt_st.line_oe = !st_ff.ref_cfg[7];
                        end else begin
                            nxt_st.state = PLLCFG_IGNORE;
                        end
                    end
                end
                default: nxt_st.state = PLLCFG_IDLE;
            endcase
        end

        // Loop ratio selection
        if (st_ff.ref_cfg[RATIO_EN_BIT]) begin
            nxt_st.fb_div = (10'(st_ff.fb_cfg) + FB_OFFSET) << 1;
            if (st_ff.ref_cfg[REF_BYPASS_BIT]) begin
                nxt_st.ref_div = REF_BYPASS_DIV;
            end else begin
                nxt_st.ref_div = 7'(st_ff.ref_cfg[REF_FIELD_MSB:0]) + REF_OFFSET;
            end
        end else begin
            nxt_st.fb_div = sel_s ? MULT_PIN_HIGH : MULT_PIN_LOW;
            nxt_st.ref_div = MULT_REF_DIV;
        end
        nxt_st.out_en = gate_s;
    end

    // Single register for the whole state
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st_ff <= '{scl_d: 1'b1, sda_d: 1'b1, state: PLLCFG_IDLE, bit_cnt: 4'h0,
                shift: 8'h00, byte_pos: 3'h0, read_dir: 1'b0, ack_seen_fall: 1'b0,
                line_oe: 1'b0, ref_cfg: REF_CFG_RST, fb_cfg: FB_CFG_RST,
                spare_cfg: SPARE_CFG_RST, fb_div: MULT_PIN_HIGH,
                ref_div: MULT_REF_DIV, out_en: 1'b0};
        end else begin
            st_ff <= nxt_st;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs from flip-flops, line value tied low; line driven only low
    assign two_wire_line_out = 1'b0;
    assign two_wire_line_oe = st_ff.line_oe;
    assign ref_divider_config = st_ff.ref_cfg;
    assign feedback_divider_config = st_ff.fb_cfg;
    assign spare_config_byte = st_ff.spare_cfg;
    assign loop_fb_division = st_ff.fb_div;
    assign loop_ref_division = st_ff.ref_div;
    assign clock_output_enable = st_ff.out_en;

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    a_ratio_bypass: assert property (@(posedge clk) disable iff (rst)
        st_ff.ref_cfg[RATIO_EN_BIT] && st_ff.ref_cfg[REF_BYPASS_BIT] |=> loop_ref_division == 7'h01)
        else $error("bypass did not force reference division of one");
    a_fb_formula: assert property (@(posedge clk) disable iff (rst)
        st_ff.ref_cfg[RATIO_EN_BIT] && $stable(st_ff.fb_cfg) |=>
        loop_fb_division == (10'($past(st_ff.fb_cfg)) + 10'h003) * 10'h002)
        else $error("feedback division wrong");
    a_ref_formula: assert property (@(posedge clk) disable iff (rst)
        st_ff.ref_cfg[RATIO_EN_BIT] && !st_ff.ref_cfg[REF_BYPASS_BIT] && $stable(st_ff.ref_cfg)
        |=> loop_ref_division == 7'($past(st_ff.ref_cfg[5:0])) + 7'h02)
        else $error("reference division wrong");
    a_pin_mult: assert property (@(posedge clk) disable iff (rst)
        !st_ff.ref_cfg[RATIO_EN_BIT] && !sel_s |=> loop_fb_division == 10'h010)
        else $error("select pin low did not give sixteen");
    a_gate_follow: assert property (@(posedge clk) disable iff (rst)
        gate_s |=> clock_output_enable)
        else $error("output gate not followed");
    a_nomatch_quiet: assert property (@(posedge clk) disable iff (rst)
        st_ff.state == PLLCFG_IGNORE |-> !two_wire_line_oe)
        else $error("line driven after address mismatch");
    a_ack_hold: assert property (@(posedge clk) disable iff (rst)
        st_ff.state == PLLCFG_ACK && scl_s && !start_cond && !stop_cond |=> two_wire_line_oe)
        else $error("acknowledge released during clock high");
    a_no_change_high: assert property (@(posedge clk) disable iff (rst)
        scl_s && st_ff.scl_d && !start_cond && !stop_cond |=> $stable(two_wire_line_oe))
        else $error("data line changed while clock high");
    // Pin mode: high select gives eight, and the reference division stays one
    a_pin_eight: assert property (@(posedge clk) disable iff (rst)
        !st_ff.ref_cfg[RATIO_EN_BIT] && sel_s |=> loop_fb_division == 10'h008)
        else $error("select pin high did not give eight");
    a_pin_refdiv: assert property (@(posedge clk) disable iff (rst)
        !st_ff.ref_cfg[RATIO_EN_BIT] |=> loop_ref_division == 7'h01)
        else $error("pin mode reference division not one");
    a_gate_off: assert property (@(posedge clk) disable iff (rst)
        !gate_s |=> !clock_output_enable)
        else $error("output gate low did not disable");
    // Bus conditions restart or end the engine wherever it stands
    a_start_rx: assert property (@(posedge clk) disable iff (rst)
        start_cond |=> st_ff.state == PLLCFG_RX && st_ff.bit_cnt == 4'h0 &&
        st_ff.byte_pos == 3'h0)
        else $error("start did not restart address reception");
    a_stop_idle: assert property (@(posedge clk) disable iff (rst)
        stop_cond |=> st_ff.state == PLLCFG_IDLE && !two_wire_line_oe)
        else $error("stop did not return to idle");
    // Address byte: acknowledge on a match, stay silent otherwise
    a_addr_ack: assert property (@(posedge clk) disable iff (rst)
        st_ff.state == PLLCFG_RX && scl_fall && st_ff.bit_cnt == BITS_PER_BYTE &&
        st_ff.byte_pos == 3'h0 && st_ff.shift[7:1] == SLAVE_ADDR
        |=> st_ff.state == PLLCFG_ACK && two_wire_line_oe)
        else $error("matching address not acknowledged");
    a_addr_miss: assert property (@(posedge clk) disable iff (rst)
        st_ff.state == PLLCFG_RX && scl_fall && st_ff.bit_cnt == BITS_PER_BYTE &&
        st_ff.byte_pos == 3'h0 && st_ff.shift[7:1] != SLAVE_ADDR
        |=> st_ff.state == PLLCFG_IGNORE && !two_wire_line_oe)
        else $error("foreign address not ignored");
    a_byte_count: assert property (@(posedge clk) disable iff (rst)
        st_ff.state == PLLCFG_RX |-> st_ff.bit_cnt <= BITS_PER_BYTE)
        else $error("more than eight bits in a byte");
    // Configuration latches: only the three config positions write them
    a_ref_latch: assert property (@(posedge clk) disable iff (rst)
        st_ff.state == PLLCFG_RX && scl_fall && st_ff.bit_cnt == BITS_PER_BYTE &&
        st_ff.byte_pos == POS_REF_CFG |=> ref_divider_config == $past(st_ff.shift))
        else $error("reference byte not latched");
    a_fb_latch: assert property (@(posedge clk) disable iff (rst)
        st_ff.state == PLLCFG_RX && scl_fall && st_ff.bit_cnt == BITS_PER_BYTE &&
        st_ff.byte_pos == POS_FB_CFG |=> feedback_divider_config == $past(st_ff.shift))
        else $error("feedback byte not latched");
    a_dummy_skip: assert property (@(posedge clk) disable iff (rst)
        st_ff.state == PLLCFG_RX && scl_fall && st_ff.bit_cnt == BITS_PER_BYTE &&
        st_ff.byte_pos != 3'h0 && st_ff.byte_pos <= POS_DUMMY_LAST
        |=> $stable(ref_divider_config) && $stable(feedback_divider_config) &&
        $stable(spare_config_byte))
        else $error("dummy byte was stored");
    a_extra_skip: assert property (@(posedge clk) disable iff (rst)
        st_ff.state == PLLCFG_RX && scl_fall && st_ff.bit_cnt == BITS_PER_BYTE &&
        st_ff.byte_pos > POS_SPARE_CFG
        |=> $stable(ref_divider_config) && $stable(feedback_divider_config) &&
        $stable(spare_config_byte))
        else $error("extra byte was stored");
    // Acknowledge slot release on writes, first data bit on reads
    a_ack_release: assert property (@(posedge clk) disable iff (rst)
        st_ff.state == PLLCFG_ACK && scl_fall && !st_ff.read_dir |=> !two_wire_line_oe)
        else $error("acknowledge not released after falling edge");
    a_read_msb: assert property (@(posedge clk) disable iff (rst)
        st_ff.state == PLLCFG_ACK && scl_fall && st_ff.read_dir
        |=> two_wire_line_oe == !ref_divider_config[7])
        else $error("read did not start with the top bit");
    a_nack_ends: assert property (@(posedge clk) disable iff (rst)
        st_ff.state == PLLCFG_TXACK && scl_fall && !st_ff.ack_seen_fall
        |=> st_ff.state == PLLCFG_IGNORE)
        else $error("master nack did not end the read");
endmodule // pllcfg_top

// ===== tb/pllcfg_master.sv
// Two-wire bus master: drives the serial clock, pulls the data line low or releases it
module pllcfg_master (
    input wire logic clk,
    input wire logic line,
    output logic scl,
    output logic pull_low
);
    timeunit 1ns;
    timeprecision 1ns;
    // Idle bus: both lines released, clock stands still between frames
    initial begin
        scl = 1'b1;
        pull_low = 1'b0;
    end
    // One 160 ns phase of the link clock
    task automatic half();
        repeat (4) @(posedge clk);
    endtask
    // Data moves only in the low phase and is sampled at the end of the high phase
    task automatic clk_bit(input logic b, output logic s);
        @(posedge clk);
        pull_low <= ~b;
        half();
        scl <= 1'b1;
        half();
        s = line;
        scl <= 1'b0;
    endtask
    task automatic start();
        @(posedge clk);
        pull_low <= 1'b1;
        half();
        scl <= 1'b0;
    endtask
    task automatic stop();
        @(posedge clk);
        pull_low <= 1'b1;
        half();
        scl <= 1'b1;
        half();
        pull_low <= 1'b0;
        half();
    endtask
    // Eight bits MSB first, then the line is released for the slave's acknowledge
    task automatic put_byte(input logic [7:0] d, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) clk_bit(d[i], s);
        clk_bit(1'b1, s);
        ack = (s === 1'b0);
    endtask
    // Read a byte, then acknowledge it or not to go on or end the read
    task automatic get_byte(input logic ack, output logic [7:0] d);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            clk_bit(1'b1, s);
            d[i] = s;
        end
        clk_bit(~ack, s);
    endtask
endmodule // pllcfg_master

// ===== tb/pll_ratio_serial_config_tb.sv
module pll_ratio_serial_config_tb import pllcfg_pkg::*;;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk, rst, scl, m_low, two_wire_line_out, two_wire_line_oe, line;
    logic mult_select_pin, output_gate_pin, clock_output_enable;
    logic [7:0] ref_divider_config, feedback_divider_config, spare_config_byte;
    logic [9:0] loop_fb_division;
    logic [6:0] loop_ref_division;
    int fails = 0;
    int n_tests = 0;
    int cycles = 0;
    ////////////////////////////////////////////////////////////////////////////
    // Wired-AND data line: low if any party pulls, otherwise the pull-up wins
    assign line = ~(m_low | (two_wire_line_oe & ~two_wire_line_out));
    pllcfg_top i_dut (.clk, .rst, .two_wire_clock_pin(scl), .two_wire_line_in(line),
        .two_wire_line_out, .two_wire_line_oe, .mult_select_pin, .output_gate_pin,
        .ref_divider_config, .feedback_divider_config, .spare_config_byte,
        .loop_fb_division, .loop_ref_division, .clock_output_enable);
    pllcfg_master i_mst (.clk(clk), .line(line), .scl(scl), .pull_low(m_low));
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    // A hung handshake would otherwise stall the run forever
    always @(posedge clk) begin
        cycles++;
        if (cycles == 40000) begin
            fails++;
            report_and_stop();
        end
    end
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic check(input logic ok, input string msg);
        n_tests++;
        if (!ok) begin
            fails++;
            $display("unexpected at %0t: %s", $time, msg);
        end
    endtask
    ////////////////////////////////////////////////////////////////////////////
    // Expected loop ratio, pin mode whenever the ratio enable is clear
    function automatic logic [9:0] exp_fb(logic [7:0] c0, logic [7:0] c1, logic pin);
        if (c0[RATIO_EN_BIT]) return ({2'b00, c1} + 10'h003) * 10'h002;
        return pin ? 10'h008 : 10'h010;
    endfunction
    function automatic logic [6:0] exp_ref(logic [7:0] c0);
        if (!c0[RATIO_EN_BIT] || c0[REF_BYPASS_BIT]) return 7'h01;
        return {1'b0, c0[5:0]} + 7'h02;
    endfunction
    // Settle the synchronisers, then compare latches and derived ratio
    task automatic check_cfg(input logic [7:0] c0, c1, c2);
        repeat (8) @(posedge clk);
        check(ref_divider_config === c0, "reference byte");
        check(feedback_divider_config === c1, "feedback byte");
        check(spare_config_byte === c2, "spare byte");
        check(loop_fb_division === exp_fb(c0, c1, mult_select_pin), "fb ratio");
        check(loop_ref_division === exp_ref(c0), "ref division");
    endtask
    task automatic write_cfg(input logic [6:0] addr, input logic [7:0] d[$], input logic ok);
        logic a;
        i_mst.start();
        i_mst.put_byte({addr, 1'b0}, a);
        check(a === ok, "address acknowledge");
        foreach (d[i]) begin
            i_mst.put_byte(d[i], a);
            check(a === ok, "data acknowledge");
        end
        i_mst.stop();
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        logic [7:0] c0, c1, c2, r;
        logic a;
        rst = 1'b1;
        mult_select_pin = 1'b1;
        output_gate_pin = 1'b0;
        r = $urandom(87);
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        repeat (3) @(posedge clk);
        check_cfg(8'h00, 8'h00, 8'h00);
        // Output gate follows its pin both ways
        output_gate_pin <= 1'b1;
        repeat (6) @(posedge clk);
        check(clock_output_enable === 1'b1, "gate on");
        output_gate_pin <= 1'b0;
        repeat (6) @(posedge clk);
        check(clock_output_enable === 1'b0, "gate off");
        mult_select_pin <= 1'b0;
        check_cfg(8'h00, 8'h00, 8'h00);
        // Corner bytes first, then random ones; an extra byte ends each write
        for (int k = 0; k < 10; k++) begin
            c0 = (k == 0) ? 8'h7F : (k == 1) ? 8'hC5 : (k == 2) ? 8'h3F : 8'($urandom);
            c1 = (k == 0) ? 8'hFF : 8'($urandom);
            c2 = 8'($urandom);
            mult_select_pin <= 1'($urandom);
            write_cfg(SLAVE_ADDR, '{8'($urandom), 8'($urandom), c0, c1, c2, ~c2}, 1'b1);
            check_cfg(c0, c1, c2);
        end
        // Each single-bit address miss must be ignored entirely
        for (int b = 0; b < 7; b++) begin
            write_cfg(SLAVE_ADDR ^ 7'(1 << b), '{8'h00, 8'h00, ~c0, ~c1, ~c2}, 1'b0);
            check_cfg(c0, c1, c2);
        end
        // Read: the slave returns the reference byte twice; the master acknowledges the first, not the second
        i_mst.start();
        i_mst.put_byte({SLAVE_ADDR, 1'b1}, a);
        check(a === 1'b1, "read address acknowledge");
        i_mst.get_byte(1'b1, r);
        check(r === c0, "read byte one");
        i_mst.get_byte(1'b0, r);
        check(r === c0, "read byte two");
        i_mst.stop();
        // Reset in mid-run clears the latches again
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        check_cfg(8'h00, 8'h00, 8'h00);
        report_and_stop();
    end
endmodule // pll_ratio_serial_config_tb
